//--- include/itrap_pkg.sv
// Shared constants and state types for the two-wire register access port.
`default_nettype none
package itrap_pkg;
  localparam int CLK_NS = 100;
  localparam int CLK_KHZ = 1000000 / CLK_NS;
  localparam int LINK_NS = 48;
  localparam int GLITCH_NS = 50;
  // Samples that must agree so that their span exceeds the glitch width.
  localparam int FILT_CYC = (GLITCH_NS + LINK_NS - 1) / LINK_NS + 1;
  localparam int FILT_W = 2;
  localparam int SCL_KHZ_STD = 100;
  localparam int SCL_KHZ_FAST = 400;
  localparam logic [15:0] UPD_ADDR = 16'h0005;
  localparam int UPD_BIT = 0;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] ACK_RISES = 4'h1;
  localparam logic [2:0] MSB_IDX = 3'h7;
  localparam logic [1:0] IDX_AHI = 2'h0;
  localparam logic [1:0] IDX_ALO = 2'h1;
  localparam logic [1:0] IDX_DATA = 2'h2;
  localparam logic [1:0] PH_SETUP = 2'h0;
  localparam logic [1:0] PH_RISE = 2'h1;
  localparam logic [1:0] PH_HIGH = 2'h2;
  localparam logic [1:0] PH_FALL = 2'h3;
  typedef enum logic [6:0] {
    TS_IDLE = 7'h01, TS_ADDR = 7'h02, TS_WR = 7'h04, TS_ACK = 7'h08,
    TS_RD = 7'h10, TS_RACK = 7'h20, TS_SKIP = 7'h40
  } itrap_tst_t;
  typedef enum logic [4:0] {
    CS_IDLE = 5'h01, CS_START = 5'h02, CS_BIT = 5'h04, CS_ACK = 5'h08, CS_STOP = 5'h10
  } itrap_cst_t;
endpackage
`default_nettype wire

//--- include/itrap_if.sv
// Open-drain two-wire link joining the controller end and the target end.
`timescale 1ns/1ps
`default_nettype none
interface itrap_if;
  logic link_clk;
  logic ctl_scl_o;
  logic ctl_scl_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;
  // Pull-ups hold both lines high unless some end drives a low.
  assign scl = ~(ctl_scl_oe & ~ctl_scl_o);
  assign sda = ~((ctl_sda_oe & ~ctl_sda_o) | (dev_sda_oe & ~dev_sda_o));
  modport dev(input link_clk, input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport ctl(input scl, input sda, output ctl_scl_o, output ctl_scl_oe,
              output ctl_sda_o, output ctl_sda_oe);
endinterface
`default_nettype wire

//--- hdl/itrap_ctrl.sv
// Controller end: makes the serial clock and moves one byte per command.
`timescale 1ns/1ps
`default_nettype none
module itrap_ctrl
  import itrap_pkg::*;
#(
  parameter int SCL_KHZ = SCL_KHZ_STD
) (
  input wire logic clock,
  input wire logic rst_n,
  itrap_if.ctl bus,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic cmd_start,
  input wire logic cmd_stop,
  input wire logic cmd_read,
  input wire logic cmd_nack,
  input wire logic [7:0] cmd_wdata,
  output logic resp_valid,
  output logic [7:0] resp_rdata,
  output logic resp_nack
);
  localparam int QTR_CYC = (CLK_KHZ + 4 * SCL_KHZ - 1) / (4 * SCL_KHZ);
  localparam logic [7:0] QTR_LAST = 8'(QTR_CYC - 1);

  itrap_cst_t st_r;
  logic [7:0] div_r;
  logic [1:0] q_r;
  logic [2:0] bit_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic scl_oe_r;
  logic sda_oe_r;
  logic start_r;
  logic stop_r;
  logic read_r;
  logic nack_r;
  logic ready_r;
  logic rv_r;
  logic rnack_r;
  logic sda_s1_r;
  logic sda_s2_r;

  wire tick = (div_r == QTR_LAST);
  wire busy = (st_r != CS_IDLE);
  wire take = (st_r == CS_IDLE) & cmd_valid & ready_r;

  assign bus.ctl_scl_o = 1'b0;
  assign bus.ctl_sda_o = 1'b0;
  assign bus.ctl_scl_oe = scl_oe_r;
  assign bus.ctl_sda_oe = sda_oe_r;
  assign cmd_ready = ready_r;
  assign resp_valid = rv_r;
  assign resp_rdata = rx_r;
  assign resp_nack = rnack_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sda_s1_r <= 1'b1;
      sda_s2_r <= 1'b1;
      div_r <= 8'h00;
    end else begin
      sda_s1_r <= bus.sda;
      sda_s2_r <= sda_s1_r;
      div_r <= (!busy || tick) ? 8'h00 : div_r + 8'h01;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= CS_IDLE;
      q_r <= PH_SETUP;
      bit_r <= MSB_IDX;
      tx_r <= 8'h00;
      rx_r <= 8'h00;
      scl_oe_r <= 1'b0;
      sda_oe_r <= 1'b0;
      start_r <= 1'b0;
      stop_r <= 1'b0;
      read_r <= 1'b0;
      nack_r <= 1'b0;
      ready_r <= 1'b0;
      rv_r <= 1'b0;
      rnack_r <= 1'b0;
    end else begin
      rv_r <= 1'b0;
      if (take) begin
        ready_r <= 1'b0;
        start_r <= cmd_start;
        stop_r <= cmd_stop;
        read_r <= cmd_read;
        nack_r <= cmd_nack;
        tx_r <= cmd_wdata;
        bit_r <= MSB_IDX;
        q_r <= PH_SETUP;
        st_r <= cmd_start ? CS_START : CS_BIT;
      end else if (st_r == CS_IDLE) begin
        ready_r <= 1'b1;
      end else if (tick) begin
        q_r <= q_r + 2'h1;
        case (st_r)
          CS_START: begin
            if (q_r == PH_SETUP) sda_oe_r <= 1'b0;
            if (q_r == PH_RISE) scl_oe_r <= 1'b0;
            if (q_r == PH_HIGH) sda_oe_r <= 1'b1;
            if (q_r == PH_FALL) begin
              scl_oe_r <= 1'b1;
              st_r <= CS_BIT;
            end
          end
          CS_BIT: begin
            if (q_r == PH_SETUP) sda_oe_r <= ~read_r & ~tx_r[7];
            if (q_r == PH_RISE) scl_oe_r <= 1'b0;
            if (q_r == PH_HIGH) rx_r <= {rx_r[6:0], sda_s2_r};
            if (q_r == PH_FALL) begin
              scl_oe_r <= 1'b1;
              tx_r <= {tx_r[6:0], 1'b0};
              bit_r <= bit_r - 3'h1;
              if (bit_r == 3'h0) st_r <= CS_ACK;
            end
          end
          CS_ACK: begin
            if (q_r == PH_SETUP) sda_oe_r <= read_r & ~nack_r;
            if (q_r == PH_RISE) scl_oe_r <= 1'b0;
            if (q_r == PH_HIGH) rnack_r <= read_r ? nack_r : sda_s2_r;
            if (q_r == PH_FALL) begin
              scl_oe_r <= 1'b1;
              st_r <= stop_r ? CS_STOP : CS_IDLE;
              rv_r <= ~stop_r;
            end
          end
          CS_STOP: begin
            if (q_r == PH_SETUP) sda_oe_r <= 1'b1;
            if (q_r == PH_RISE) scl_oe_r <= 1'b0;
            if (q_r == PH_HIGH) sda_oe_r <= 1'b0;
            if (q_r == PH_FALL) begin
              st_r <= CS_IDLE;
              rv_r <= 1'b1;
            end
          end
          default: st_r <= CS_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/itrap_target.sv
// Target end: two-wire register access port with 16-bit register pointer.
//
// Notes on behaviour
// - Ignore pulses under 50 ns on both lines.
// - Works at 100 kHz and 400 kHz.
// - Target only; never drives the clock.
// - Answer only own address, one of four.
// - Data changes while clock low; sampled high.
// - Start and stop mark frame boundaries.
// - Eight bits, MSB first, then ack slot.
// - Receiver pulls data low to acknowledge.
// - Write: two pointer bytes, high first.
// - No limit on bytes per transfer.
// - Read sends data from current pointer.
// - Read nack: release line, go idle.
// - Write ends with stop after ack.
// - Start/stop anytime discards partial byte.
// - Pointer-only write sets later read address.
// - Random read uses repeated start.
// - Every start restarts the receiver.
// - Writing bit 0 at 0x0005 pulses update.
`timescale 1ns/1ps
`default_nettype none
module itrap_target
  import itrap_pkg::*;
#(
  // Upper five address bits; the value is arbitrary.
  parameter logic [4:0] ADDR_BASE = 5'h0b
) (
  input wire logic clock,
  input wire logic rst_n,
  itrap_if.dev bus,
  input wire logic [1:0] addr_sel,
  output logic [15:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  output logic reg_update
);
  // Link domain: bit 1 is the clock line, bit 0 the data line.
  logic [1:0] pin_s1_r;
  logic [1:0] pin_s2_r;
  logic [1:0] pin_q_r;
  logic [1:0] pin_f;
  logic [1:0] sel_s1_r;
  logic [1:0] sel_s2_r;
  itrap_tst_t st_r;
  itrap_tst_t st_nxt;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] sh_r;
  logic [7:0] sh_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic [1:0] idx_r;
  logic [1:0] idx_nxt;
  logic [7:0] ahi_r;
  logic [7:0] ahi_nxt;
  logic [15:0] ptr_r;
  logic [15:0] ptr_nxt;
  logic rd_dir_r;
  logic rd_dir_nxt;
  logic oe_r;
  logic oe_nxt;
  logic req_go;
  logic req_wr_nxt;
  logic [15:0] req_addr_nxt;
  logic req_tgl_r;
  logic req_wr_r;
  logic [15:0] req_addr_r;
  logic [7:0] req_wdata_r;
  logic ack_s1_r;
  logic ack_s2_r;
  logic ack_q_r;
  logic [7:0] rbuf_r;
  // Clock domain.
  logic rq_s1_r;
  logic rq_s2_r;
  logic rq_q_r;
  logic ack_tgl_r;
  logic [7:0] rdata_r;
  logic rd_wait_r;
  logic [15:0] reg_addr_r;
  logic [7:0] reg_wdata_r;
  logic reg_wr_r;
  logic reg_rd_r;
  logic reg_update_r;

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_filt
      logic [FILT_W-1:0] run_r;
      logic f_r;
      always_ff @(posedge bus.link_clk or negedge rst_n) begin
        if (!rst_n) begin
          run_r <= '0;
          f_r <= 1'b1;
        end else if (pin_s2_r[g] == f_r) begin
          run_r <= '0;
        end else if (run_r == FILT_W'(FILT_CYC - 1)) begin
          run_r <= '0;
          f_r <= pin_s2_r[g];
        end else begin
          run_r <= run_r + FILT_W'(1);
        end
      end
      assign pin_f[g] = f_r;
    end
  endgenerate

  wire scl_f = pin_f[1];
  wire sda_f = pin_f[0];
  wire scl_q = pin_q_r[1];
  wire sda_q = pin_q_r[0];
  wire scl_rise = scl_f & ~scl_q;
  wire scl_fall = ~scl_f & scl_q;
  wire start_c = scl_f & scl_q & sda_q & ~sda_f;
  wire stop_c = scl_f & scl_q & ~sda_q & sda_f;
  wire [6:0] own_addr = {ADDR_BASE, sel_s2_r};
  wire addr_hit = (sh_r[7:1] == own_addr);
  wire byte_done = scl_fall & (cnt_r == BYTE_BITS);
  wire ack_done = scl_fall & (cnt_r == ACK_RISES);
  wire send_next = ack_done & (((st_r == TS_ACK) & rd_dir_r) | ((st_r == TS_RACK) & ~sh_r[0]));
  wire ack_edge = ack_s2_r ^ ack_q_r;

  assign bus.dev_sda_o = 1'b0;
  assign bus.dev_sda_oe = oe_r;

  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r;
    sh_nxt = sh_r;
    tx_nxt = tx_r;
    idx_nxt = idx_r;
    ahi_nxt = ahi_r;
    ptr_nxt = ptr_r;
    rd_dir_nxt = rd_dir_r;
    oe_nxt = oe_r;
    req_go = 1'b0;
    req_wr_nxt = req_wr_r;
    req_addr_nxt = req_addr_r;
    if (scl_rise) begin
      cnt_nxt = cnt_r + 4'h1;
      sh_nxt = {sh_r[6:0], sda_f};
    end
    if (send_next) begin
      st_nxt = TS_RD;
      cnt_nxt = 4'h0;
      oe_nxt = ~rbuf_r[7];
      tx_nxt = {rbuf_r[6:0], 1'b0};
      ptr_nxt = ptr_r + 16'h0001;
      req_go = 1'b1;
      req_wr_nxt = 1'b0;
      req_addr_nxt = ptr_r + 16'h0001;
    end else begin
      case (st_r)
        TS_ADDR: begin
          if (byte_done) begin
            if (addr_hit) begin
              st_nxt = TS_ACK;
              cnt_nxt = 4'h0;
              oe_nxt = 1'b1;
              rd_dir_nxt = sh_r[0];
              req_go = sh_r[0];
              req_wr_nxt = 1'b0;
              req_addr_nxt = ptr_r;
            end else begin
              st_nxt = TS_SKIP;
            end
          end
        end
        TS_WR: begin
          if (byte_done) begin
            st_nxt = TS_ACK;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b1;
            case (idx_r)
              IDX_AHI: begin
                ahi_nxt = sh_r;
                idx_nxt = IDX_ALO;
              end
              IDX_ALO: begin
                ptr_nxt = {ahi_r, sh_r};
                idx_nxt = IDX_DATA;
              end
              default: begin
                req_go = 1'b1;
                req_wr_nxt = 1'b1;
                req_addr_nxt = ptr_r;
                ptr_nxt = ptr_r + 16'h0001;
              end
            endcase
          end
        end
        TS_ACK: begin
          if (ack_done) begin
            st_nxt = TS_WR;
            cnt_nxt = 4'h0;
            oe_nxt = 1'b0;
          end
        end
        TS_RD: begin
          if (scl_fall) begin
            if (cnt_r == BYTE_BITS) begin
              st_nxt = TS_RACK;
              cnt_nxt = 4'h0;
              oe_nxt = 1'b0;
            end else begin
              oe_nxt = ~tx_r[7];
              tx_nxt = {tx_r[6:0], 1'b0};
            end
          end
        end
        TS_RACK: begin
          if (ack_done) begin
            st_nxt = TS_IDLE;
          end
        end
        default: st_nxt = st_r;
      endcase
    end
    if (start_c) begin
      st_nxt = TS_ADDR;
      cnt_nxt = 4'h0;
      idx_nxt = IDX_AHI;
      oe_nxt = 1'b0;
    end else if (stop_c) begin
      st_nxt = TS_IDLE;
      oe_nxt = 1'b0;
    end
  end

  always_ff @(posedge bus.link_clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_r <= 2'h3;
      pin_s2_r <= 2'h3;
      pin_q_r <= 2'h3;
      sel_s1_r <= 2'h0;
      sel_s2_r <= 2'h0;
      ack_s1_r <= 1'b0;
      ack_s2_r <= 1'b0;
      ack_q_r <= 1'b0;
      rbuf_r <= 8'h00;
    end else begin
      pin_s1_r <= {bus.scl, bus.sda};
      pin_s2_r <= pin_s1_r;
      pin_q_r <= pin_f;
      sel_s1_r <= addr_sel;
      sel_s2_r <= sel_s1_r;
      ack_s1_r <= ack_tgl_r;
      ack_s2_r <= ack_s1_r;
      ack_q_r <= ack_s2_r;
      if (ack_edge) rbuf_r <= rdata_r;
    end
  end

  always_ff @(posedge bus.link_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= TS_IDLE;
      cnt_r <= 4'h0;
      sh_r <= 8'h00;
      tx_r <= 8'h00;
      idx_r <= IDX_AHI;
      ahi_r <= 8'h00;
      ptr_r <= 16'h0000;
      rd_dir_r <= 1'b0;
      oe_r <= 1'b0;
      req_tgl_r <= 1'b0;
      req_wr_r <= 1'b0;
      req_addr_r <= 16'h0000;
      req_wdata_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      sh_r <= sh_nxt;
      tx_r <= tx_nxt;
      idx_r <= idx_nxt;
      ahi_r <= ahi_nxt;
      ptr_r <= ptr_nxt;
      rd_dir_r <= rd_dir_nxt;
      oe_r <= oe_nxt;
      if (req_go) begin
        req_tgl_r <= ~req_tgl_r;
        req_wr_r <= req_wr_nxt;
        req_addr_r <= req_addr_nxt;
        req_wdata_r <= sh_r;
      end
    end
  end

  // Clock domain: request fields are stable while the toggle crosses.
  wire req_edge = rq_s2_r ^ rq_q_r;
  wire do_wr = req_edge & req_wr_r;
  wire upd_hit = (req_addr_r == UPD_ADDR) & req_wdata_r[UPD_BIT];

  assign reg_addr = reg_addr_r;
  assign reg_wdata = reg_wdata_r;
  assign reg_wr = reg_wr_r;
  assign reg_rd = reg_rd_r;
  assign reg_update = reg_update_r;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rq_s1_r <= 1'b0;
      rq_s2_r <= 1'b0;
      rq_q_r <= 1'b0;
      ack_tgl_r <= 1'b0;
      rdata_r <= 8'h00;
      rd_wait_r <= 1'b0;
      reg_addr_r <= 16'h0000;
      reg_wdata_r <= 8'h00;
      reg_wr_r <= 1'b0;
      reg_rd_r <= 1'b0;
      reg_update_r <= 1'b0;
    end else begin
      rq_s1_r <= req_tgl_r;
      rq_s2_r <= rq_s1_r;
      rq_q_r <= rq_s2_r;
      reg_wr_r <= do_wr;
      reg_rd_r <= req_edge & ~req_wr_r;
      reg_update_r <= do_wr & upd_hit;
      rd_wait_r <= reg_rd_r;
      if (req_edge) begin
        reg_addr_r <= req_addr_r;
        reg_wdata_r <= req_wdata_r;
      end
      if (rd_wait_r) rdata_r <= reg_rdata;
      if (do_wr || rd_wait_r) ack_tgl_r <= ~ack_tgl_r;
    end
  end
endmodule
`default_nettype wire

//--- dv/itrap_assertions.sv
// Protocol checker watching the shared two-wire link.
`timescale 1ns/1ps
`default_nettype none
module itrap_assertions (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic ctl_scl_oe,
  input wire logic ctl_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  logic scl_r, sda_r, byte0_r, rd_r, act_r, nk_r, mis_r;
  logic [3:0] cnt_r;
  wire logic rise = scl & ~scl_r;
  wire logic st_ev = scl & scl_r & sda_r & ~sda;
  wire logic sp_ev = scl & scl_r & ~sda_r & sda;
  wire logic ninth = rise & (cnt_r == 4'h8);
  // Tracks the bit slot and the frame phase as seen on the wires.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
      {byte0_r, rd_r, act_r, nk_r, mis_r} <= 5'h00;
      cnt_r <= 4'h0;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
      if (st_ev || sp_ev) begin
        byte0_r <= st_ev;
        {act_r, nk_r, mis_r} <= 3'h0;
        cnt_r <= 4'h0;
      end else if (rise) begin
        cnt_r <= ninth ? 4'h0 : cnt_r + 4'h1;
        if (byte0_r && cnt_r == 4'h7) rd_r <= sda;
        if (ninth && byte0_r) begin
          byte0_r <= 1'b0;
          act_r <= ~sda;
          mis_r <= sda;
        end
        if (ninth && act_r && rd_r && sda) nk_r <= 1'b1;
      end
    end
  end
  default clocking cb @(posedge link_clk); endclocking
  default disable iff (!rst_n);
  sequence wr_ninth;
    ninth && act_r && !rd_r;
  endsequence
  sequence ack_held;
    dev_sda_oe [*8];
  endsequence
  scl_by_ctl_a: assert property (!scl |-> ctl_scl_oe)
    else $error("clock line low without the controller");
  dev_edge_a: assert property ((dev_sda_oe != $past(dev_sda_oe)) |-> !scl)
    else $error("target data changed while clock high");
  no_fight_a: assert property (scl && dev_sda_oe |-> !ctl_sda_oe)
    else $error("both ends drive data while clock high");
  wr_ack_a: assert property (wr_ninth |-> ack_held)
    else $error("write byte not acknowledged by target");
  bit_quiet_a: assert property (rise && (byte0_r || act_r && !rd_r) && cnt_r != 4'h8
    |-> !dev_sda_oe)
    else $error("target drove data during a received bit");
  rd_slot_a: assert property (ninth && act_r && rd_r |-> !dev_sda_oe)
    else $error("target held data in its read ack slot");
  nack_idle_a: assert property (nk_r |-> !dev_sda_oe)
    else $error("target drove data after a read nack");
  mism_idle_a: assert property (mis_r |-> !dev_sda_oe)
    else $error("unaddressed target drove data");
endmodule
`default_nettype wire

//--- dv/i2c_target_reg_access_port_bench.sv
// Self-checking bench: the controller end talks to the target end over the link.
`timescale 1ns/1ps
`default_nettype none
module i2c_target_reg_access_port_bench
  import itrap_pkg::*;
;
  localparam logic [4:0] TGT_BASE = 5'h0b;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack;
  logic cmd_ready, resp_valid, resp_nack, reg_wr, reg_rd, reg_update;
  logic [7:0] cmd_wdata, resp_rdata, reg_wdata, reg_rdata;
  logic [15:0] reg_addr;
  logic [1:0] addr_sel;
  logic [24:0] wq[$];
  int fail_count = 0;
  int n_compared = 0;
  itrap_if bus_if();
  itrap_ctrl #(.SCL_KHZ(SCL_KHZ_STD)) itrap_ctrl_inst (.clock(clock), .rst_n(rst_n),
    .bus(bus_if), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_start(cmd_start),
    .cmd_stop(cmd_stop), .cmd_read(cmd_read), .cmd_nack(cmd_nack), .cmd_wdata(cmd_wdata),
    .resp_valid(resp_valid), .resp_rdata(resp_rdata), .resp_nack(resp_nack));
  itrap_target #(.ADDR_BASE(TGT_BASE)) itrap_target_inst (.clock(clock), .rst_n(rst_n),
    .bus(bus_if), .addr_sel(addr_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .reg_update(reg_update));
  itrap_assertions itrap_assertions_inst (.link_clk(bus_if.link_clk), .rst_n(rst_n),
    .ctl_scl_oe(bus_if.ctl_scl_oe), .ctl_sda_oe(bus_if.ctl_sda_oe),
    .dev_sda_oe(bus_if.dev_sda_oe), .scl(bus_if.scl), .sda(bus_if.sda));
  always #50 clock = ~clock;
  initial begin
    bus_if.link_clk = 1'b0;
    #7;
    forever #24 bus_if.link_clk = ~bus_if.link_clk;
  end
  function automatic logic [7:0] fv(input logic [15:0] a);
    return a[7:0] ^ a[15:8];
  endfunction
  function automatic logic [7:0] ab(input logic [1:0] s, input logic r);
    return {TGT_BASE, s, r};
  endfunction
  // Register file stand-in; read data lands one cycle after the request.
  always @(posedge clock) begin
    reg_rdata <= (reg_rd === 1'b1) ? fv(reg_addr) : ~reg_rdata;
    if (reg_wr === 1'b1) wq.push_back({reg_update, reg_addr, reg_wdata});
  end
  task automatic complete_run();
    $display("compared %0d mismatched %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [24:0] seen, input logic [24:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wt(input logic resp, input int lim);
    int k;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while ((resp ? resp_valid : cmd_ready) !== 1'b1 && k < lim);
    if ((resp ? resp_valid : cmd_ready) !== 1'b1) begin
      fail_count++;
      complete_run();
    end
  endtask
  // Flags are start, stop, read, nack from the top bit down.
  task automatic op(input logic [3:0] f, input logic [7:0] wd, input logic en,
                    input logic [7:0] ex);
    @(posedge clock);
    {cmd_start, cmd_stop, cmd_read, cmd_nack} <= f;
    cmd_wdata <= wd;
    cmd_valid <= 1'b1;
    wt(1'b0, 50);
    @(posedge clock);
    cmd_valid <= 1'b0;
    wt(1'b1, 2000);
    chk("nack", {24'h0, resp_nack}, {24'h0, en});
    if (f[1]) chk("rdata", {17'h0, resp_rdata}, {17'h0, ex});
  endtask
  task automatic wchk(input logic [24:0] exp);
    logic [24:0] v;
    v = (wq.size() > 0) ? wq.pop_front() : 25'hx;
    chk("write", v, exp);
  endtask
  initial begin
    {cmd_valid, cmd_start, cmd_stop, cmd_read, cmd_nack} = 5'h00;
    cmd_wdata = 8'h00;
    addr_sel = 2'h0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    repeat (20) @(posedge clock);
    op(4'h8, ab(2'h0, 1'b0), 1'h0, 8'h00);
    op(4'h0, 8'h00, 1'h0, 8'h00);
    op(4'h0, 8'h04, 1'h0, 8'h00);
    op(4'h0, 8'hfe, 1'h0, 8'h00);
    op(4'h0, 8'h01, 1'h0, 8'h00);
    op(4'h0, 8'h01, 1'h0, 8'h00);
    op(4'h4, 8'h5a, 1'h0, 8'h00);
    wchk({1'b0, 16'h0004, 8'hfe});
    wchk({1'b1, UPD_ADDR, 8'h01});
    wchk({1'b0, 16'h0006, 8'h01});
    wchk({1'b0, 16'h0007, 8'h5a});
    op(4'h8, ab(2'h0, 1'b0), 1'h0, 8'h00);
    op(4'h0, 8'h12, 1'h0, 8'h00);
    op(4'h4, 8'hfe, 1'h0, 8'h00);
    chk("writes", 25'(wq.size()), 25'h0);
    op(4'h8, ab(2'h0, 1'b1), 1'h0, 8'h00);
    op(4'h2, 8'hff, 1'h0, fv(16'h12fe));
    op(4'h2, 8'hff, 1'h0, fv(16'h12ff));
    op(4'h7, 8'hff, 1'h1, fv(16'h1300));
    op(4'h8, ab(2'h0, 1'b0), 1'h0, 8'h00);
    op(4'h0, 8'hab, 1'h0, 8'h00);
    op(4'h0, 8'h01, 1'h0, 8'h00);
    op(4'h8, ab(2'h0, 1'b1), 1'h0, 8'h00);
    op(4'h7, 8'hff, 1'h1, fv(16'hab01));
    op(4'h8, ab(2'h0, 1'b1), 1'h0, 8'h00);
    op(4'h7, 8'hff, 1'h1, fv(16'hab02));
    op(4'h8, ab(2'h0, 1'b0), 1'h0, 8'h00);
    op(4'h0, 8'h44, 1'h0, 8'h00);
    op(4'h8, ab(2'h0, 1'b0), 1'h0, 8'h00);
    op(4'h0, 8'h00, 1'h0, 8'h00);
    op(4'h0, 8'h40, 1'h0, 8'h00);
    op(4'h4, 8'h99, 1'h0, 8'h00);
    wchk({1'b0, 16'h0040, 8'h99});
    for (int s = 0; s < 4; s++) begin
      @(posedge clock);
      addr_sel <= 2'(s);
      repeat (20) @(posedge clock);
      op(4'hc, ab(2'(s), 1'b0), 1'h0, 8'h00);
      op(4'h8, ab(2'(s + 1), 1'b0), 1'h1, 8'h00);
      op(4'h4, 8'h77, 1'h1, 8'h00);
    end
    chk("writes", 25'(wq.size()), 25'h0);
    complete_run();
  end
endmodule
`default_nettype wire
